/* File: hw/pdt_tick_gen.v */
// tick generator: selects one of four clock sources and divides by the prescale plus one
// assumes external oscillator inputs are asynchronous to the system clock
`default_nettype none
`include "pdt_defines.vh"

module pdt_tick_gen #(
  parameter PRESCALE_W = 16
) (
  input  wire                  clk_i,        // system clock
  input  wire                  srst_i,       // synchronous reset
  input  wire                  ce_i,         // clock enable
  input  wire [1:0]            src_sel_i,    // clock source select
  input  wire                  osc1_i,       // internal oscillator one
  input  wire                  osc2_i,       // internal oscillator two
  input  wire                  crystal_oscillator_clock_i,       // crystal oscillator
  input  wire [PRESCALE_W-1:0] prescale_i,   // input clocks per tick minus one
  input  wire                  restart_i,    // restart the prescale count
  output wire                  tick_o        // one-cycle decrement tick
);

  // ------------------------------------------------------------
  // source synchronisers and edge detect
  // ------------------------------------------------------------
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [2:0] sync3_q;
  reg       src_edge;
  reg [PRESCALE_W-1:0] presc_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else if (ce_i) begin
      sync1_q <= {crystal_oscillator_clock_i, osc2_i, osc1_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // sources run well below the system clock; faster ones alias
  always @* begin
    case (src_sel_i)
      `PDT_SRC_SYS:  src_edge = 1'b1;
      `PDT_SRC_OSC1: src_edge = sync2_q[0] & ~sync3_q[0];
      `PDT_SRC_OSC2: src_edge = sync2_q[1] & ~sync3_q[1];
      `PDT_SRC_CRYSTAL_OSCILLATOR_CLOCK: src_edge = sync2_q[2] & ~sync3_q[2];
      default:       src_edge = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // prescale counter
  // ------------------------------------------------------------
  assign tick_o = ce_i & src_edge & (presc_q == {PRESCALE_W{1'b0}});

  always @(posedge clk_i) begin
    if (srst_i) begin
      presc_q <= {PRESCALE_W{1'b0}};
    end else if (ce_i) begin
      if (restart_i) begin
        presc_q <= prescale_i;
      end else if (src_edge) begin
        if (presc_q == {PRESCALE_W{1'b0}}) begin
          presc_q <= prescale_i;
        end else begin
          presc_q <= presc_q - {{(PRESCALE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // pdt_tick_gen
`default_nettype wire

/* File: hw/pdt_timer.v */
// periodic down-counter timer with apb register slave
// assumes an apb master on the system clock; oscillator pins asynchronous
//
// Overview of operation
// - 32-bit down counter loaded from period
// - decrement by one each tick while running
// - one-cycle interrupt pulse when count hits zero
// - prescale sets input clocks per tick
// - clock source: system, two oscillators, crystal
// - overflow flag in control register
// - writing reload bit reloads counter from period
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
`include "pdt_defines.vh"

module pdt_timer #(
  parameter CNT_W      = 32,
  parameter PRESCALE_W = 16
) (
  input  wire        CLK_SYS_I,     // system clock, 20 mhz
  input  wire        SRST_I,        // synchronous reset, high
  input  wire        CE_I,          // clock enable, freezes state when low
  input  wire        PSEL_I,        // apb select
  input  wire        PENABLE_I,     // apb enable
  input  wire        PWRITE_I,      // apb direction
  input  wire [7:0]  PADDR_I,       // apb byte address
  input  wire [31:0] PWDATA_I,      // apb write data
  output wire        PREADY_O,      // apb ready
  output reg  [31:0] PRDATA_O,      // apb read data
  output wire        PSLVERR_O,     // apb error
  input  wire        OSC1_I,        // internal oscillator one
  input  wire        OSC2_I,        // internal oscillator two
  input  wire        CRYSTAL_OSCILLATOR_CLOCK_I,        // crystal oscillator
  output reg         TIMER_IRQ_O    // interrupt pulse at zero
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [CNT_W-1:0]      count_q;
  reg [CNT_W-1:0]      count_d;
  reg [CNT_W-1:0]      period_q;
  reg [CNT_W-1:0]      period_d;
  reg [PRESCALE_W-1:0] prescale_q;
  reg [PRESCALE_W-1:0] prescale_d;
  reg [1:0]            clksel_q;
  reg [1:0]            clksel_d;
  reg                  stop_q;
  reg                  stop_d;
  reg                  ovf_q;
  reg                  ovf_d;
  reg                  wrapped_q;
  reg                  wrapped_d;
  reg                  irq_d;
  reg [31:0]           rdata_d;
  wire                 tick;

  function sel_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel_hit = (addr == off);
    end
  endfunction

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire access       = PSEL_I & PENABLE_I & CE_I;
  wire wr           = access & PWRITE_I;
  wire rd_setup     = CE_I & PSEL_I & ~PENABLE_I & ~PWRITE_I;
  wire hit_count    = sel_hit(PADDR_I, `PDT_OFF_COUNT);
  wire hit_period   = sel_hit(PADDR_I, `PDT_OFF_PERIOD);
  wire hit_prescale = sel_hit(PADDR_I, `PDT_OFF_PRESCALE);
  wire hit_ctrl     = sel_hit(PADDR_I, `PDT_OFF_CTRL);
  wire hit_clksel   = sel_hit(PADDR_I, `PDT_OFF_CLKSEL);
  wire known        = hit_count | hit_period | hit_prescale | hit_ctrl | hit_clksel;
  wire wr_ctrl      = wr & hit_ctrl;
  wire reload       = wr_ctrl & PWDATA_I[`PDT_CTRL_RELOAD];
  wire ovf_clr      = wr_ctrl & PWDATA_I[`PDT_CTRL_OVF];
  wire at_zero      = (count_q == {CNT_W{1'b0}});
  wire run_tick     = tick & ~stop_q;
  // a reload in the same cycle wins, so no pulse rides on a fresh period
  wire zero_hit     = run_tick & ~wrapped_q & at_zero & ~reload;

  // zero-wait slave; unmapped addresses answer with an error
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~known;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always @* begin
    period_d   = period_q;
    prescale_d = prescale_q;
    clksel_d   = clksel_q;
    stop_d     = stop_q;
    if (wr & hit_period) begin
      period_d = PWDATA_I[CNT_W-1:0];
    end
    if (wr & hit_prescale) begin
      prescale_d = PWDATA_I[PRESCALE_W-1:0];
    end
    if (wr & hit_clksel) begin
      clksel_d = PWDATA_I[1:0];
    end
    if (wr_ctrl) begin
      stop_d = PWDATA_I[`PDT_CTRL_STOP];
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      period_q   <= `PDT_PERIOD_RST;
      prescale_q <= `PDT_PRESCALE_RST;
      clksel_q   <= `PDT_CLKSEL_RST;
      stop_q     <= 1'b0;
    end else if (CE_I) begin
      period_q   <= period_d;
      prescale_q <= prescale_d;
      clksel_q   <= clksel_d;
      stop_q     <= stop_d;
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // wrapped_q marks that zero was seen; the next tick reloads the period
  always @* begin
    count_d   = count_q;
    wrapped_d = wrapped_q;
    if (reload) begin
      count_d   = period_q;
      wrapped_d = 1'b0;
    end else if (run_tick) begin
      if (wrapped_q) begin
        count_d   = period_q;
        wrapped_d = 1'b0;
      end else if (at_zero) begin
        wrapped_d = 1'b1;
      end else begin
        count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      count_q   <= `PDT_PERIOD_RST;
      wrapped_q <= 1'b0;
    end else if (CE_I) begin
      count_q   <= count_d;
      wrapped_q <= wrapped_d;
    end
  end

  // ------------------------------------------------------------
  // overflow flag and interrupt
  // ------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  always @* begin
    irq_d = zero_hit;
    ovf_d = ovf_q;
    if (zero_hit) begin
      ovf_d = 1'b1;
    end else if (ovf_clr) begin
      ovf_d = 1'b0;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ovf_q       <= 1'b0;
      TIMER_IRQ_O <= 1'b0;
    end else if (CE_I) begin
      ovf_q       <= ovf_d;
      TIMER_IRQ_O <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // captured in the setup cycle so it stands through the access phase
  always @* begin
    rdata_d = 32'h00000000;
    case (PADDR_I)
      `PDT_OFF_COUNT:    rdata_d[CNT_W-1:0] = count_q;
      `PDT_OFF_PERIOD:   rdata_d[CNT_W-1:0] = period_q;
      `PDT_OFF_PRESCALE: rdata_d[PRESCALE_W-1:0] = prescale_q;
      `PDT_OFF_CTRL: begin
        rdata_d[`PDT_CTRL_OVF]  = ovf_q;
        rdata_d[`PDT_CTRL_STOP] = stop_q;
      end
      `PDT_OFF_CLKSEL:   rdata_d[1:0] = clksel_q;
      default:           rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (rd_setup) begin
      PRDATA_O <= rdata_d;
    end
  end

  pdt_tick_gen #(
    .PRESCALE_W (PRESCALE_W)
  ) u_tick (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .ce_i       (CE_I),
    .src_sel_i  (clksel_q),
    .osc1_i     (OSC1_I),
    .osc2_i     (OSC2_I),
    .crystal_oscillator_clock_i     (CRYSTAL_OSCILLATOR_CLOCK_I),
    .prescale_i (prescale_q),
    .restart_i  (reload),
    .tick_o     (tick)
  );

endmodule // pdt_timer
`default_nettype wire

/* File: include/pdt_defines.vh */
// constants of the periodic down-counter timer: apb offsets, fields, reset values
// assumes inclusion by bare name from the design files
`ifndef PDT_DEFINES_VH
`define PDT_DEFINES_VH

`define PDT_ADDR_W        8
`define PDT_OFF_COUNT     8'h00
`define PDT_OFF_PERIOD    8'h04
`define PDT_OFF_PRESCALE  8'h08
`define PDT_OFF_CTRL      8'h0c
`define PDT_OFF_CLKSEL    8'h10

`define PDT_CTRL_STOP     4
`define PDT_CTRL_RELOAD   5
`define PDT_CTRL_OVF      7

`define PDT_PERIOD_RST    32'hffffffff
`define PDT_PRESCALE_RST  16'h0000
`define PDT_CLKSEL_RST    2'h0

`define PDT_SRC_SYS       2'h0
`define PDT_SRC_OSC1      2'h1
`define PDT_SRC_OSC2      2'h2
`define PDT_SRC_CRYSTAL_OSCILLATOR_CLOCK      2'h3

`endif

/* File: sim/pdt_timer_checker.sv */
// port assertions for the periodic down-counter timer
// assumes binding to pdt_timer, one clock domain
`default_nettype none
`include "pdt_defines.vh"

module pdt_timer_checker (
  input wire logic        CLK_SYS_I,   // system clock
  input wire logic        SRST_I,      // synchronous reset
  input wire logic        CE_I,        // clock enable
  input wire logic        PSEL_I,      // apb select
  input wire logic        PENABLE_I,   // apb enable
  input wire logic        PWRITE_I,    // apb direction
  input wire logic        PREADY_O,    // apb ready
  input wire logic        PSLVERR_O,   // apb error
  input wire logic        TIMER_IRQ_O, // interrupt pulse
  input wire logic        OSC1_I,      // oscillator one
  input wire logic        OSC2_I,      // oscillator two
  input wire logic        CRYSTAL_OSCILLATOR_CLOCK_I,      // crystal
  input wire logic [7:0]  PADDR_I,     // apb address
  input wire logic [31:0] PWDATA_I,    // apb write data
  input wire logic [31:0] PRDATA_O     // apb read data
);
  timeunit 1ns;
  timeprecision 1ns;
  // misaligned offsets count as unmapped too
  wire unm = PADDR_I > `PDT_OFF_CLKSEL || PADDR_I[1:0] != 2'h0;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  sequence s_rd;
    PSEL_I && !PENABLE_I && !PWRITE_I && CE_I;
  endsequence
  sequence s_rd_ctrl;
    s_rd ##0 PADDR_I == `PDT_OFF_CTRL;
  endsequence
  sequence s_rd_unm;
    s_rd ##0 unm;
  endsequence
  chk_ready_high: assert property (PREADY_O) else $error("pready low");
  // a low enable freezes the pulse, so only enabled cycles must end it
  chk_irq_single: assert property (TIMER_IRQ_O && CE_I |=> !TIMER_IRQ_O)
    else $error("irq wider than one cycle");
  chk_ce_freeze: assert property (!CE_I |=> $stable(TIMER_IRQ_O) && $stable(PRDATA_O))
    else $error("outputs moved with enable low");
  chk_err_map: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == unm)
    else $error("pslverr wrong in access");
  chk_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
    else $error("pslverr outside access");
  chk_rst_clear: assert property (disable iff (1'b0)
    SRST_I |=> !TIMER_IRQ_O && PRDATA_O == 32'h0) else $error("reset not clearing");
  chk_rdata_hold: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I)
    |=> $stable(PRDATA_O)) else $error("prdata moved without read");
  chk_reload_rd0: assert property (s_rd_ctrl |=> !PRDATA_O[`PDT_CTRL_RELOAD])
    else $error("reload bit reads one");
  chk_unmap_rd0: assert property (s_rd_unm |=> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
endmodule // pdt_timer_checker
`default_nettype wire

/* File: sim/pdt_timer_tb.sv */
// self-checking bench of the periodic down-counter timer over apb
// assumes pdt_timer and pdt_timer_checker compiled first
`default_nettype none
`include "pdt_defines.vh"

module pdt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, srst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, err;
  logic        osc1 = 0, osc2 = 0, crystal_oscillator_clock = 0, prdy, perr, irq;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  int          k[4] = '{1, 4, 6, 8};

  pdt_timer u_dut (.CLK_SYS_I(clk), .SRST_I(srst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(prdy), .PRDATA_O(prdata), .PSLVERR_O(perr), .OSC1_I(osc1),
    .OSC2_I(osc2), .CRYSTAL_OSCILLATOR_CLOCK_I(crystal_oscillator_clock), .TIMER_IRQ_O(irq));

  initial begin
    forever #25 clk = ~clk;
  end

  // source periods of 4, 6 and 8 cycles keep intervals exact
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    osc1 <= cyc % 4 < 2;
    osc2 <= cyc % 6 < 3;
    crystal_oscillator_clock <= cyc % 8 < 4;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rdata = prdata;
    err   = perr;
    {psel, pen} <= 2'b00;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    apb(0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdata);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 1000);
  endtask

  // ---
  // scenarios
  // ---
  task t_reset;
    rd(`PDT_OFF_PERIOD, `PDT_PERIOD_RST);
    rd(`PDT_OFF_PRESCALE, 32'h0);
    rd(`PDT_OFF_CTRL, 32'h0);
    rd(`PDT_OFF_CLKSEL, 32'h0);
    $display("test reset done");
  endtask

  task t_load;
    wr(`PDT_OFF_PERIOD, 32'h64);
    wr(`PDT_OFF_CTRL, 32'h30);
    wr(`PDT_OFF_COUNT, 32'h5);
    rd(`PDT_OFF_COUNT, 32'h64);
    rd(`PDT_OFF_CTRL, 32'h10);
    $display("test load done");
  endtask

  task t_rate;
    int n;
    wr(`PDT_OFF_PERIOD, 32'h2);
    wr(`PDT_OFF_PRESCALE, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(`PDT_OFF_CLKSEL, 32'(s));
      wr(`PDT_OFF_CTRL, 32'h20);
      wait_irq(n);
      wait_irq(n);
      wait_irq(n);
      chk("irq interval", 32'(4 * 2 * k[s]), 32'(n));
    end
    $display("test rate done");
  endtask

  task t_ovf;
    rd(`PDT_OFF_CTRL, 32'h80);
    wr(`PDT_OFF_CTRL, 32'h10);
    wr(`PDT_OFF_CTRL, 32'h90);
    rd(`PDT_OFF_CTRL, 32'h10);
    $display("test overflow done");
  endtask

  // four enabled edges lie between the two count samples
  task t_freeze;
    logic [31:0] c1;
    wr(`PDT_OFF_CLKSEL, 32'h0);
    wr(`PDT_OFF_PRESCALE, 32'h0);
    wr(`PDT_OFF_PERIOD, 32'h1000);
    wr(`PDT_OFF_CTRL, 32'h20);
    apb(0, `PDT_OFF_COUNT, 32'h0);
    c1 = rdata;
    @(posedge clk);
    ce <= 0;
    wr(`PDT_OFF_PERIOD, 32'h55);
    ce <= 1;
    rd(`PDT_OFF_COUNT, c1 - 32'h4);
    rd(`PDT_OFF_PERIOD, 32'h1000);
    $display("test freeze done");
  endtask

  task t_unmap;
    rd(8'h14, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    $display("test unmapped done");
  endtask

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    t_reset;
    t_load;
    t_rate;
    t_ovf;
    t_freeze;
    t_unmap;
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule // pdt_timer_tb

bind pdt_timer pdt_timer_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I),
  .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TIMER_IRQ_O(TIMER_IRQ_O),
  .OSC1_I(OSC1_I), .OSC2_I(OSC2_I), .CRYSTAL_OSCILLATOR_CLOCK_I(CRYSTAL_OSCILLATOR_CLOCK_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O));
`default_nettype wire
